// *** design/fps_defs.svh ***
// offsets, field positions, reset values and codes of the page-select block
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define FPS_ADDR_W 12
`define FPS_OFF_CTL 12'hFF8
`define FPS_OFF_PAGE 12'hFF9
`define FPS_OFF_STAT 12'hFFA

// ****************************************
// page-select fields
// ****************************************
`define FPS_INFO_BIT 7
`define FPS_PAGE_MSB 6
`define FPS_PAGE_W 7
`define FPS_PAGE_RST 8'h00
`define FPS_SECT_RST 8'h00

// ****************************************
// program memory geometry
// ****************************************
`define FPS_PADDR_W 16
`define FPS_PAGE_BYTES 512
`define FPS_PAGE_SHIFT 9
`define FPS_INFO_BASE 16'hFE00
`define FPS_INFO_TOP 16'hFFFF
`define FPS_SECT_LSB 4

// ****************************************
// unlock and redirect codes
// ****************************************
`define FPS_KEY1 8'hA5
`define FPS_KEY2 8'h5A
`define FPS_REDIRECT 8'h5E

// ****************************************
// synchroniser depth
// ****************************************
`define FPS_SYNC_STAGES 3

`endif

// *** design/fps_pkg.sv ***
// types shared by the page-select block
package fps_pkg;

  typedef enum logic [1:0] {
    FPS_LOCKED,
    FPS_KEY1_SEEN,
    FPS_UNLOCKED,
    FPS_SECT_SEL
  } fps_lock_e;

  typedef enum logic [1:0] {
    FPS_PROT_NONE,
    FPS_PROT_READ,
    FPS_PROT_ALL
  } fps_prot_e;

endpackage

// *** design/fps_sel_if.sv ***
// carries page field, info enable and address to the decoder and its hits
`timescale 1ns/10ps
`include "fps_defs.svh"

interface fps_sel_if;
  logic [`FPS_PADDR_W-1:0] addr;
  logic [`FPS_PAGE_W-1:0] page;
  logic info_area_enable;
  logic page_hit;
  logic info_hit;

  modport ctl (output addr, output page, output info_area_enable,
               input page_hit, input info_hit);
  modport dec (input addr, input page, input info_area_enable,
               output page_hit, output info_hit);
endinterface

// *** design/fps_sync3.sv ***
// three-stage synchroniser; output moves only when stages two and three agree
`timescale 1ns/10ps
`include "fps_defs.svh"

module fps_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // per bit: accept only a settled value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

// *** design/fps_addr_dec.sv ***
// decodes a program address against the selected page and the info window
`timescale 1ns/10ps
`include "fps_defs.svh"

module fps_addr_dec (
  fps_sel_if.dec sel
);
  // upper seven address bits name the 512-byte page
  assign sel.page_hit =
    (sel.addr[`FPS_PADDR_W-1:`FPS_PAGE_SHIFT] == sel.page);

  assign sel.info_hit = sel.info_area_enable &&
    (sel.addr >= `FPS_INFO_BASE) && (sel.addr <= `FPS_INFO_TOP);
endmodule

// *** design/fps_top.sv ***
// page select, sector protect and option-bit protection for the flash
// How it works
// - Writes to the shared address go to page select unless the controller is unlocked and was sent the redirect code, which steers writes to sector protect.
// - Program memory splits into 512-byte pages and the page field names one.
// - During page erase only addresses whose top seven bits equal the page field are selected.
// - The page field is program address bits 15..9 and picks the page for erase; its bits 6..4 pick the sector protect bit.
// - With info enable set the information area answers at FE00 through FFFF.
// - With info enable clear the information area is never selected.
// - The two option bits select one of three protection levels.
// - A programmed read-protect option stops the debugger reading user code.
`timescale 1ns/10ps
`include "fps_defs.svh"

module fps_top
  import fps_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`FPS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic read_protect_option,
  input wire logic write_protect_option,
  input wire logic [`FPS_PADDR_W-1:0] prog_addr,
  input wire logic erase_active,
  input wire logic dbg_read_req,
  output logic erase_sel_r,
  output logic info_sel_r,
  output logic main_sel_r,
  output logic dbg_read_block_r,
  output logic prog_block_r,
  output logic [1:0] prot_level_r
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_s1_r;
  logic rst_n_s;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_s <= rst_s1_r;
    end
  end

  // ****************************************
  // option bit inputs
  // ****************************************
  logic [1:0] opt_q;
  logic rp_prog;
  logic wp_prog;

  fps_sync3 #(.W(2)) u_opt_sync (
    .clk(clk),
    .rst_n(rst_n_s),
    .d({write_protect_option, read_protect_option}),
    .q(opt_q)
  );

  assign rp_prog = opt_q[0];
  assign wp_prog = opt_q[1];

  // ****************************************
  // bus decode
  // ****************************************
  logic wr_ctl;
  logic wr_page;
  logic rd_hit;

  assign wr_ctl = reg_wr && (reg_addr == `FPS_OFF_CTL);
  assign wr_page = reg_wr && (reg_addr == `FPS_OFF_PAGE);
  assign rd_hit = reg_rd;

  // ****************************************
  // unlock sequence
  // ****************************************
  fps_lock_e lock_r;
  fps_lock_e lock_nxt;

  always_comb begin
    lock_nxt = lock_r;
    unique case (lock_r)
      FPS_LOCKED: begin
        if (wr_ctl && reg_wdata == `FPS_KEY1) begin
          lock_nxt = FPS_KEY1_SEEN;
        end
      end
      FPS_KEY1_SEEN: begin
        if (wr_ctl) begin
          lock_nxt = (reg_wdata == `FPS_KEY2) ? FPS_UNLOCKED : FPS_LOCKED;
        end
      end
      FPS_UNLOCKED: begin
        if (wr_ctl) begin
          lock_nxt = FPS_LOCKED;
        end else if (wr_page && reg_wdata == `FPS_REDIRECT) begin
          lock_nxt = FPS_SECT_SEL;
        end
      end
      FPS_SECT_SEL: begin
        if (wr_ctl) begin
          lock_nxt = FPS_LOCKED;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      lock_r <= FPS_LOCKED;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // ****************************************
  // page select and sector protect
  // ****************************************
  logic [7:0] page_sel_r;
  logic [7:0] sect_prot_r;
  logic redirect_wr;

  // while unlocked, the redirect code itself does not land in page select
  assign redirect_wr = (lock_r == FPS_UNLOCKED) &&
                       (reg_wdata == `FPS_REDIRECT);

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      page_sel_r <= `FPS_PAGE_RST;
    end else if (wr_page && lock_r != FPS_SECT_SEL && !redirect_wr) begin
      page_sel_r <= reg_wdata;
    end
  end

  // sector bits only ever get set; cleared by reset
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sect_prot_r <= `FPS_SECT_RST;
    end else if (wr_page && lock_r == FPS_SECT_SEL) begin
      sect_prot_r <= sect_prot_r | reg_wdata;
    end
  end

  // ****************************************
  // protection level
  // ****************************************
  fps_prot_e prot_nxt;

  always_comb begin
    if (wp_prog) begin
      prot_nxt = FPS_PROT_ALL;
    end else if (rp_prog) begin
      prot_nxt = FPS_PROT_READ;
    end else begin
      prot_nxt = FPS_PROT_NONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      prot_level_r <= FPS_PROT_NONE;
      prog_block_r <= 1'b0;
      dbg_read_block_r <= 1'b0;
    end else begin
      prot_level_r <= prot_nxt;
      prog_block_r <= (prot_nxt == FPS_PROT_ALL);
      dbg_read_block_r <= dbg_read_req && rp_prog;
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  fps_sel_if sel ();
  logic sect_locked;
  logic [2:0] sect_idx;

  assign sel.addr = prog_addr;
  assign sel.page = page_sel_r[`FPS_PAGE_MSB:0];
  assign sel.info_area_enable = page_sel_r[`FPS_INFO_BIT];

  fps_addr_dec u_dec (
    .sel(sel)
  );

  assign sect_idx = page_sel_r[`FPS_PAGE_MSB:`FPS_SECT_LSB];
  assign sect_locked = sect_prot_r[sect_idx];

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      erase_sel_r <= 1'b0;
      info_sel_r <= 1'b0;
      main_sel_r <= 1'b0;
    end else begin
      erase_sel_r <= erase_active && sel.page_hit && !sect_locked &&
                     (lock_r != FPS_LOCKED) && !wp_prog;
      info_sel_r <= sel.info_hit;
      main_sel_r <= !sel.info_hit;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      reg_rdata <= 8'h00;
    end else if (rd_hit) begin
      unique case (reg_addr)
        `FPS_OFF_PAGE: begin
          reg_rdata <= (lock_r == FPS_SECT_SEL) ? sect_prot_r
                                                : page_sel_r;
        end
        `FPS_OFF_STAT: begin
          reg_rdata <= {2'h0, wp_prog, rp_prog, prot_level_r, lock_r};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_s);

  sequence s_key1;
    lock_r == FPS_LOCKED && wr_ctl && reg_wdata == `FPS_KEY1;
  endsequence

  sequence s_key2;
    lock_r == FPS_KEY1_SEEN && wr_ctl && reg_wdata == `FPS_KEY2;
  endsequence

  a_key1_seen: assert property (
    s_key1 |=> lock_r == FPS_KEY1_SEEN)
    else $error("first key not taken");

  a_unlock_keys: assert property (
    s_key2 |=> lock_r == FPS_UNLOCKED)
    else $error("unlock keys did not unlock");

  a_page_write_lands: assert property (
    wr_page && lock_r != FPS_SECT_SEL && !redirect_wr
      |=> page_sel_r == $past(reg_wdata))
    else $error("page write lost");

  a_redirect_code: assert property (
    wr_page && lock_r == FPS_UNLOCKED && reg_wdata == `FPS_REDIRECT
      |=> lock_r == FPS_SECT_SEL && $stable(page_sel_r))
    else $error("redirect code not honoured");

  a_erase_match: assert property (
    erase_sel_r |-> $past(prog_addr[15:9]) == $past(page_sel_r[6:0]))
    else $error("erase hit outside selected page");

  a_erase_hit: assert property (
    erase_active && prog_addr[15:9] == page_sel_r[6:0] && !sect_locked &&
    lock_r == FPS_UNLOCKED && !wp_prog |=> erase_sel_r)
    else $error("erase missed selected page");

  a_info_window: assert property (
    page_sel_r[7] && prog_addr >= 16'hFE00 |=> info_sel_r && !main_sel_r)
    else $error("info area not mapped");

  a_info_off: assert property (
    rst_n_s && !page_sel_r[7] |=> !info_sel_r && main_sel_r)
    else $error("info area selected while disabled");

  a_prot_level: assert property (
    prot_level_r != 2'h3 && (prog_block_r == (prot_level_r == FPS_PROT_ALL)))
    else $error("bad protection level");

  a_dbg_block: assert property (
    dbg_read_req && rp_prog |=> dbg_read_block_r)
    else $error("debugger read not blocked");

  a_page_readback: assert property (
    reg_rd && reg_addr == 12'hFF9 && lock_r != FPS_SECT_SEL
      |=> reg_rdata == $past(page_sel_r))
    else $error("page select read back wrong");

  a_prog_block: assert property (
    wp_prog |=> prog_block_r && prot_level_r == FPS_PROT_ALL)
    else $error("write protect did not block programming");

  a_erase_locked: assert property (
    lock_r == FPS_LOCKED |=> !erase_sel_r)
    else $error("erase selected while locked");

endmodule

// *** sim/fps_top_tb_top.sv ***
// self-checking bench for the page-select and protection block
`timescale 1ns/10ps
`include "fps_defs.svh"

module fps_top_tb_top
  import fps_pkg::*;
;
  // ****************************************
  // signals and decode table
  // ****************************************
  typedef struct {
    logic [7:0] page;
    logic [15:0] addr;
    logic ea;
    logic er;
    logic inf;
  } fps_row_s;

  logic clk, rstn, reg_wr, reg_rd, rp, wp, erase_active, dbg_read_req;
  logic [`FPS_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [`FPS_PADDR_W-1:0] prog_addr;
  logic erase_sel_r, info_sel_r, main_sel_r, dbg_read_block_r, prog_block_r;
  logic [1:0] prot_level_r;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  fps_row_s rows[9] = '{
    '{8'h05, 16'h0A00, 1'b1, 1'b1, 1'b0},
    '{8'h05, 16'h0BFF, 1'b1, 1'b1, 1'b0},
    '{8'h05, 16'h0C00, 1'b1, 1'b0, 1'b0},
    '{8'h05, 16'h09FF, 1'b1, 1'b0, 1'b0},
    '{8'h7F, 16'hFE00, 1'b1, 1'b1, 1'b0},
    '{8'hFF, 16'hFE00, 1'b0, 1'b0, 1'b1},
    '{8'h80, 16'hFFFF, 1'b0, 1'b0, 1'b1},
    '{8'h80, 16'hFDFF, 1'b0, 1'b0, 1'b0},
    '{8'h00, 16'hFFFF, 1'b1, 1'b0, 1'b0}
  };

  fps_top i_fps_top (
    .clk(clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .read_protect_option(rp),
    .write_protect_option(wp),
    .prog_addr(prog_addr),
    .erase_active(erase_active),
    .dbg_read_req(dbg_read_req),
    .erase_sel_r(erase_sel_r),
    .info_sel_r(info_sel_r),
    .main_sel_r(main_sel_r),
    .dbg_read_block_r(dbg_read_block_r),
    .prog_block_r(prog_block_r),
    .prot_level_r(prot_level_r)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // bus, decode and compare tasks
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic dec(input logic [15:0] a, input logic ea, input logic dr);
    @(posedge clk);
    prog_addr <= a;
    erase_active <= ea;
    dbg_read_req <= dr;
    @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    rp = 1'b0;
    wp = 1'b0;
    prog_addr = '0;
    erase_active = 1'b0;
    dbg_read_req = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`FPS_OFF_PAGE, d);
    chk(d, `FPS_PAGE_RST, "page reset");
    rd(12'h100, d);
    chk(d, 8'h00, "unmapped read");
    wr(`FPS_OFF_CTL, `FPS_KEY1);
    wr(`FPS_OFF_CTL, `FPS_KEY2);
    foreach (rows[i]) begin
      wr(`FPS_OFF_PAGE, rows[i].page);
      rd(`FPS_OFF_PAGE, d);
      chk(d, rows[i].page, "page readback");
      dec(rows[i].addr, rows[i].ea, 1'b0);
      chk({7'h00, erase_sel_r}, {7'h00, rows[i].er}, "erase sel");
      chk({7'h00, info_sel_r}, {7'h00, rows[i].inf}, "info sel");
      chk({7'h00, main_sel_r}, {7'h00, !rows[i].inf}, "main sel");
    end
    // shared address: redirect code while unlocked
    wr(`FPS_OFF_PAGE, 8'h05);
    wr(`FPS_OFF_PAGE, `FPS_REDIRECT);
    rd(`FPS_OFF_STAT, d);
    chk({6'h00, d[1:0]}, 8'h03, "lock state");
    rd(`FPS_OFF_PAGE, d);
    chk(d, `FPS_SECT_RST, "sector read");
    wr(`FPS_OFF_PAGE, 8'h02);
    rd(`FPS_OFF_PAGE, d);
    chk(d, 8'h02, "sector write");
    dec(16'h0A00, 1'b1, 1'b0);
    chk({7'h00, erase_sel_r}, 8'h01, "erase open sector");
    wr(`FPS_OFF_PAGE, 8'h01);
    rd(`FPS_OFF_PAGE, d);
    chk(d, 8'h03, "sector bits kept");
    dec(16'h0A00, 1'b1, 1'b0);
    chk({7'h00, erase_sel_r}, 8'h00, "erase shut sector");
    wr(`FPS_OFF_CTL, 8'h00);
    rd(`FPS_OFF_PAGE, d);
    chk(d, 8'h05, "page kept");
    wr(`FPS_OFF_PAGE, `FPS_REDIRECT);
    rd(`FPS_OFF_PAGE, d);
    chk(d, `FPS_REDIRECT, "locked redirect");
    dec(16'hBC00, 1'b1, 1'b0);
    chk({7'h00, erase_sel_r}, 8'h00, "erase while locked");
    wr(`FPS_OFF_CTL, `FPS_KEY1);
    wr(`FPS_OFF_CTL, `FPS_KEY2);
    dec(16'hBC00, 1'b1, 1'b0);
    chk({7'h00, erase_sel_r}, 8'h01, "erase after unlock");
    // option bits to protection level
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      rp <= k[0];
      wp <= k[1];
      repeat (8) @(posedge clk);
      #1;
      chk({6'h00, prot_level_r}, k[1] ? 8'h02 : {7'h00, k[0]},
          "level");
      chk({7'h00, prog_block_r}, {7'h00, k[1]}, "prog block");
      rd(`FPS_OFF_STAT, d);
      chk({6'h00, d[5:4]}, {6'h00, k[1], k[0]}, "status opts");
      dec(16'hBC00, 1'b1, 1'b0);
      chk({7'h00, erase_sel_r}, {7'h00, !k[1]}, "erase vs wp");
      if (k < 2) begin
        dec(16'h0000, 1'b0, 1'b1);
        chk({7'h00, dbg_read_block_r}, {7'h00, k[0]}, "dbg block");
      end
    end
    // second reset in mid-run clears page and lock state
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`FPS_OFF_PAGE, d);
    chk(d, `FPS_PAGE_RST, "page after reset");
    rd(`FPS_OFF_STAT, d);
    chk({6'h00, d[1:0]}, 8'h00, "lock after reset");
    give_verdict();
  end
endmodule
